// ---- bench/erc_pin_model.sv ----
// erc_pin_model: external devices on the six active-low request pins.
// assumes bench commands on clk; a released pin floats high on its pull-up.
`timescale 1ns/1ps
`default_nettype none
module erc_pin_model (
  input  wire logic       clk,
  input  wire logic [5:0] hold_low,
  output logic      [5:0] pin_n
);
  // devices pull their pin low one clock after the command
  always_ff @(posedge clk) begin
    pin_n <= ~hold_low;
  end
endmodule
`default_nettype wire

// ---- bench/erc_top_test.sv ----
// erc_top_test: register, sensing and acknowledge scenarios for erc_top.
// assumes erc_pkg, erc_top and erc_pin_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module erc_top_test;
  logic            clk = 1'b0;
  logic            reset = 1'b1;
  logic            standby = 1'b0;
  logic            reg_wr = 1'b0;
  logic            reg_rd = 1'b0;
  logic [3:0]      reg_addr = 4'h0;
  logic [7:0]      reg_wdata = 8'h00;
  logic [7:0]      reg_rdata;
  logic [7:0]      rv;
  logic [5:0]      hold_low = 6'h00;
  logic [5:0]      ack = 6'h00;
  logic [5:0]      pin_n;
  logic [5:0]      irq_request;
  logic [5:0][7:0] irq_vector;
  int              num_errors = 0;
  int              n_compared = 0;
  // free-running 125 MHz clock
  always #4 clk = ~clk;
  erc_pin_model u_erc_pin_model (.clk(clk), .hold_low(hold_low), .pin_n(pin_n));
  erc_top u_erc_top (.clk(clk), .reset(reset), .standby(standby), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .external_request_pin_n(pin_n), .exception_ack(ack), .irq_request(irq_request),
    .irq_vector(irq_vector));
  task automatic end_of_test;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  task automatic pulse(input logic [5:0] m, input int hold);
    @(posedge clk);
    hold_low <= m;
    repeat (hold) @(posedge clk);
    hold_low <= 6'h00;
    repeat (5) @(posedge clk);
  endtask
  task automatic wait_irq(input logic [5:0] exp);
    for (int k = 0; k < 10 && irq_request !== exp; k++) @(posedge clk);
    #1 chk({2'h0, irq_request}, {2'h0, exp});
    if (irq_request !== exp) end_of_test();
  endtask
  task automatic t_reset;
    rd(erc_pkg::OFS_FLAGS); chk(rv, 8'h00);
    rd(erc_pkg::OFS_ENABLES); chk(rv, 8'h00);
    rd(erc_pkg::OFS_SENSE); chk(rv, 8'h00);
    for (int i = 0; i < 6; i++) chk(irq_vector[i], 8'h0c + 8'(i));
  endtask
  task automatic t_level;
    wr(erc_pkg::OFS_ENABLES, 8'hc0);
    wr(erc_pkg::OFS_SENSE, 8'hc0);
    pulse(6'h05, 1);
    wait_irq(6'h00);
    wr(erc_pkg::OFS_ENABLES, 8'hc1);
    wait_irq(6'h01);
    wr(erc_pkg::OFS_FLAGS, 8'hff);
    rd(erc_pkg::OFS_FLAGS); chk(rv, 8'h05);
    rd(erc_pkg::OFS_SENSE); chk(rv, 8'hc0);
    @(posedge clk);
    ack <= 6'h05;
    @(posedge clk);
    ack <= 6'h00;
    rd(erc_pkg::OFS_FLAGS); chk(rv, 8'h00);
  endtask
  task automatic t_edge;
    wr(erc_pkg::OFS_SENSE, 8'h3f);
    wr(erc_pkg::OFS_ENABLES, 8'h18);
    pulse(6'h08, 20);
    wr(erc_pkg::OFS_FLAGS, 8'h00);
    rd(erc_pkg::OFS_FLAGS); chk(rv, 8'h08);
    wr(erc_pkg::OFS_FLAGS, 8'h00);
    rd(erc_pkg::OFS_FLAGS); chk(rv, 8'h00);
    pulse(6'h10, 1);
    wait_irq(6'h10);
    @(posedge clk);
    ack <= 6'h10;
    @(posedge clk);
    ack <= 6'h00;
    wait_irq(6'h00);
  endtask
  task automatic t_standby;
    pulse(6'h02, 1);
    @(posedge clk);
    standby <= 1'b1;
    @(posedge clk);
    standby <= 1'b0;
    rd(erc_pkg::OFS_FLAGS); chk(rv, 8'h00);
    rd(erc_pkg::OFS_ENABLES); chk(rv, 8'h00);
    rd(erc_pkg::OFS_SENSE); chk(rv, 8'h00);
  endtask
  // reset, then the scenarios in turn
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_level();
    t_edge();
    t_standby();
    end_of_test();
  end
endmodule
`default_nettype wire

// ---- hw/erc_pkg.sv ----
// erc_pkg: constants and types shared by the external request capture block.
// assumes a plain register port with byte-wide registers at small word offsets.
package erc_pkg;

  localparam int unsigned CHANNELS = 6;

  // register offsets on the plain register port
  localparam logic [3:0] OFS_FLAGS   = 4'h0;
  localparam logic [3:0] OFS_ENABLES = 4'h4;
  localparam logic [3:0] OFS_SENSE   = 4'h8;

  // reset values
  localparam logic [7:0] RST_FLAGS   = 8'h00;
  localparam logic [7:0] RST_ENABLES = 8'h00;
  localparam logic [7:0] RST_SENSE   = 8'h00;

  // field layout: channel bits sit in the low six bits
  localparam int unsigned CH_LSB = 0;
  localparam int unsigned CH_MSB = 5;

  // first exception vector number, channel 0
  localparam logic [7:0] VEC_BASE = 8'h0c;

  // sense select encodings
  localparam logic SENSE_LEVEL = 1'b0;
  localparam logic SENSE_EDGE  = 1'b1;

  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } erc_req_t;

endpackage

// ---- hw/erc_top.sv ----
// erc_top: six active-low external request channels with flag, enable and sense registers.
// assumes request pins are asynchronous and acknowledges come from logic on clk.
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - flag register clears to zero on reset and standby entry.
// - flag register bits 7 and 6 always read zero.
// - software writes can only clear flags; writing one leaves them.
// - writing zero clears a flag only after it was read as one.
// - level sense: flag sets while the pin is low.
// - edge sense: flag sets on a falling edge of the pin.
// - level sense: acknowledge clears the flag while the pin is high.
// - edge sense: acknowledge clears the flag.
// - enable register clears to zero on reset and standby entry.
// - low six enable bits gate each channel; reset disabled.
// - enable bits 7 and 6 are plain storage without effect.
// - sense register clears to zero, level sensing, on reset and standby.
// - each sense bit picks level or edge for its own pin.
// - sense bits 7 and 6 are plain storage without effect.
// - channels map in order to vector numbers twelve to seventeen.
// - pins are sensed whatever their port direction.
module erc_top (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic                    standby,
  input  wire logic [3:0]              reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [7:0]              reg_rdata,
  input  wire logic [5:0]              external_request_pin_n,
  input  wire logic [5:0]              exception_ack,
  output logic      [5:0]              irq_request,
  output logic      [5:0][7:0]         irq_vector
);

  erc_pkg::erc_req_t req;
  logic [5:0] sync1, sync2, prev;
  logic [5:0] next_sync1, next_sync2, next_prev;
  logic [5:0] request_flag_bit, next_request_flag_bit;
  logic [5:0] read_seen, next_read_seen;
  logic [7:0] ext_request_enables, next_ext_request_enables;
  logic [7:0] ext_sense_select, next_ext_sense_select;
  logic [7:0] next_reg_rdata;
  logic [5:0] set_ev, clr_ev, sw_clr;
  logic       clr_all;

  // decode of a register offset
  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign clr_all = reset | standby;

  // next values of the pin samples; only the second flop reads the first
  always_comb begin
    next_sync1 = external_request_pin_n;
    next_sync2 = sync1;
    next_prev  = sync2;
  end

  // pin synchroniser and previous sample
  // two flop sync
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1 <= 6'h3f;
      sync2 <= 6'h3f;
      prev  <= 6'h3f;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      prev  <= next_prev;
    end
  end

  // per-channel set and clear terms
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_ch
      assign set_ev[g] = (ext_sense_select[g] == erc_pkg::SENSE_LEVEL) ? ~sync2[g]
                                                                        : (prev[g] & ~sync2[g]);
      assign clr_ev[g] = exception_ack[g] &
                         ((ext_sense_select[g] == erc_pkg::SENSE_EDGE) | sync2[g]);
      assign sw_clr[g] = req.wr & hit(req.addr, erc_pkg::OFS_FLAGS) &
                         ~req.wdata[g] & read_seen[g];
      assign irq_request[g] = request_flag_bit[g] & ext_request_enables[g];
      assign irq_vector[g] = erc_pkg::VEC_BASE + 8'(g);
    end
  endgenerate

  // next state of flags, read markers and control registers
  always_comb begin
    next_request_flag_bit    = request_flag_bit;
    next_read_seen           = read_seen;
    next_ext_request_enables = ext_request_enables;
    next_ext_sense_select    = ext_sense_select;
    next_reg_rdata           = 8'h00;
    next_request_flag_bit = (request_flag_bit & ~(sw_clr | clr_ev)) | set_ev;
    // a clear consumes the read marker
    next_read_seen = read_seen & ~(sw_clr | clr_ev);
    if (req.rd) begin
      if (hit(req.addr, erc_pkg::OFS_FLAGS)) begin
        next_reg_rdata = {2'b00, request_flag_bit};
        next_read_seen = next_read_seen | request_flag_bit;
      end else if (hit(req.addr, erc_pkg::OFS_ENABLES)) begin
        next_reg_rdata = ext_request_enables;
      end else if (hit(req.addr, erc_pkg::OFS_SENSE)) begin
        next_reg_rdata = ext_sense_select;
      end
    end
    if (req.wr && hit(req.addr, erc_pkg::OFS_ENABLES)) begin
      next_ext_request_enables = req.wdata;
    end
    if (req.wr && hit(req.addr, erc_pkg::OFS_SENSE)) begin
      next_ext_sense_select = req.wdata;
    end
  end

  // register stage
  // reset and standby
  always_ff @(posedge clk) begin
    if (clr_all) begin
      request_flag_bit    <= erc_pkg::RST_FLAGS[5:0];
      read_seen           <= 6'h00;
      ext_request_enables <= erc_pkg::RST_ENABLES;
      ext_sense_select    <= erc_pkg::RST_SENSE;
      reg_rdata           <= 8'h00;
    end else begin
      request_flag_bit    <= next_request_flag_bit;
      read_seen           <= next_read_seen;
      ext_request_enables <= next_ext_request_enables;
      ext_sense_select    <= next_ext_sense_select;
      reg_rdata           <= next_reg_rdata;
    end
  end

  // checks on flag, register clearing, request gating and synchroniser behaviour
  property p_clr_all;
    @(posedge clk) clr_all |=> (request_flag_bit == 6'h00) && (ext_request_enables == 8'h00)
                                && (ext_sense_select == 8'h00);
  endproperty
  a_clr_all: assert property (p_clr_all) else $error("registers not cleared");

  property p_upper_zero;
    @(posedge clk) disable iff (clr_all)
      (req.rd && hit(req.addr, erc_pkg::OFS_FLAGS)) |=> (reg_rdata[7:6] == 2'b00);
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("flag upper bits not zero");

  property p_no_sw_set;
    @(posedge clk) disable iff (clr_all)
      (request_flag_bit[0] == 1'b0 && set_ev[0] == 1'b0) |=> request_flag_bit[0] == 1'b0;
  endproperty
  a_no_sw_set: assert property (p_no_sw_set) else $error("flag set without cause");

  sequence s_read_one;
    req.rd && hit(req.addr, erc_pkg::OFS_FLAGS) && request_flag_bit[0];
  endsequence
  property p_read_clear;
    @(posedge clk) disable iff (clr_all)
      s_read_one ##1 (req.wr && hit(req.addr, erc_pkg::OFS_FLAGS) && !req.wdata[0]
                      && !set_ev[0]) |=> !request_flag_bit[0];
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("flag not cleared after read");

  property p_level_set;
    @(posedge clk) disable iff (clr_all)
      (!ext_sense_select[1] && !sync2[1]) |=> request_flag_bit[1];
  endproperty
  a_level_set: assert property (p_level_set) else $error("level request missed");

  property p_edge_set;
    @(posedge clk) disable iff (clr_all)
      (ext_sense_select[2] && $fell(sync2[2])) |=> request_flag_bit[2];
  endproperty
  a_edge_set: assert property (p_edge_set) else $error("edge request missed");

  property p_ack_clear;
    @(posedge clk) disable iff (clr_all)
      (exception_ack[3] && (ext_sense_select[3] || sync2[3]) && !set_ev[3])
        |=> !request_flag_bit[3];
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("acknowledge did not clear");

  property p_gate;
    @(posedge clk) disable iff (clr_all)
      irq_request[4] |-> (request_flag_bit[4] && ext_request_enables[4]);
  endproperty
  a_gate: assert property (p_gate) else $error("request without flag and enable");

  property p_sync;
    @(posedge clk) disable iff (clr_all)
      ##2 (sync2 == $past(external_request_pin_n, 2));
  endproperty
  a_sync: assert property (p_sync) else $error("pin sync depth wrong");

  // level acknowledge with the pin high clears the flag
  property p_level_ack_clear;
    @(posedge clk) disable iff (clr_all)
      (exception_ack[2] && !ext_sense_select[2] && sync2[2]) |=> !request_flag_bit[2];
  endproperty
  a_level_ack_clear: assert property (p_level_ack_clear) else $error("level ack kept flag");

  // level acknowledge with the pin still low keeps the flag
  property p_level_ack_hold;
    @(posedge clk) disable iff (clr_all)
      (!ext_sense_select[0] && !sync2[0] && exception_ack[0]) |=> request_flag_bit[0];
  endproperty
  a_level_ack_hold: assert property (p_level_ack_hold) else $error("low pin flag lost");

  // a flag never read as one survives software writes
  property p_no_read_no_clear;
    @(posedge clk) disable iff (clr_all)
      (request_flag_bit[3] && !read_seen[3] && !exception_ack[3]) |=> request_flag_bit[3];
  endproperty
  a_no_read_no_clear: assert property (p_no_read_no_clear) else $error("unread flag cleared");

  // edge sense ignores a steady pin level
  property p_edge_steady;
    @(posedge clk) disable iff (clr_all)
      (ext_sense_select[2] && !request_flag_bit[2] && (prev[2] == sync2[2]))
        |=> !request_flag_bit[2];
  endproperty
  a_edge_steady: assert property (p_edge_steady) else $error("edge flag set on level");

  // read data idle at zero outside the answer cycle
  property p_rdata_idle;
    @(posedge clk) disable iff (clr_all)
      !req.rd |=> (reg_rdata == 8'h00);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

  // the full enable byte is stored
  property p_enable_write;
    @(posedge clk) disable iff (clr_all)
      (req.wr && hit(req.addr, erc_pkg::OFS_ENABLES)) |=> (ext_request_enables == $past(req.wdata));
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable byte not stored");

  // the full sense byte is stored
  property p_sense_write;
    @(posedge clk) disable iff (clr_all)
      (req.wr && hit(req.addr, erc_pkg::OFS_SENSE)) |=> (ext_sense_select == $past(req.wdata));
  endproperty
  a_sense_write: assert property (p_sense_write) else $error("sense byte not stored");

  // writing one to a set flag leaves it set
  property p_sw_one_keep;
    @(posedge clk) disable iff (clr_all)
      (request_flag_bit[0] && req.wr && hit(req.addr, erc_pkg::OFS_FLAGS) && req.wdata[0]
       && !exception_ack[0]) |=> request_flag_bit[0];
  endproperty
  a_sw_one_keep: assert property (p_sw_one_keep) else $error("write of one cleared flag");

  // writes to unmapped offsets leave the control bytes alone
  property p_unmapped_write;
    @(posedge clk) disable iff (clr_all)
      (req.wr && !hit(req.addr, erc_pkg::OFS_FLAGS) && !hit(req.addr, erc_pkg::OFS_ENABLES)
       && !hit(req.addr, erc_pkg::OFS_SENSE)) |=> ($stable(ext_request_enables)
       && $stable(ext_sense_select));
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("stray write landed");

  // only the low six enable bits gate requests
  property p_irq_all;
    @(posedge clk) disable iff (clr_all)
      irq_request == (request_flag_bit & ext_request_enables[5:0]);
  endproperty
  a_irq_all: assert property (p_irq_all) else $error("request gating wrong");

  // a flag read answers with the flags of the read cycle
  sequence s_flag_read;
    req.rd && hit(req.addr, erc_pkg::OFS_FLAGS);
  endsequence
  property p_read_data;
    @(posedge clk) disable iff (clr_all)
      s_flag_read |=> (reg_rdata == {2'b00, $past(request_flag_bit)});
  endproperty
  a_read_data: assert property (p_read_data) else $error("flag read data wrong");

  // edge acknowledge clears the flag whatever the pin
  sequence s_edge_ack;
    ext_sense_select[4] && exception_ack[4] && !set_ev[4];
  endsequence
  property p_edge_ack_clear;
    @(posedge clk) disable iff (clr_all)
      s_edge_ack |=> !request_flag_bit[4];
  endproperty
  a_edge_ack_clear: assert property (p_edge_ack_clear) else $error("edge ack kept flag");

  // one channel's sense bit does not change another's
  property p_sense_own;
    @(posedge clk) disable iff (clr_all)
      (ext_sense_select[5] && !ext_sense_select[0] && !sync2[0]) |=> request_flag_bit[0];
  endproperty
  a_sense_own: assert property (p_sense_own) else $error("sense bits not independent");

endmodule

`default_nettype wire
